//--- hw/flash_ctl_map.svh
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
`define UNLOCK_FIRST      8'h55
`define UNLOCK_SECOND     8'hAA
`define CTRL_READ_BIT     0
`define CTRL_WRITE_BIT    1
`define CTRL_PERMIT_BIT   2
`define CTRL_CALIBRATION_SPACE_SELECT_BIT   6
`define BLOCK_LAST        2'h3
`define ROW_FIRST_LAST    4'h3
`define ERASE_TIME_US     4000
`define POWERUP_TIME_US   72000
`define CLOCK_MHZ         250
`define SETUP_CYCLES      2
`endif

//--- hw/flash_ctl_pkg.sv
package flash_ctl_pkg;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_RDWAIT = 3'b001,
        ST_RDACC  = 3'b010,
        ST_SETUP  = 3'b011,
        ST_ERASE  = 3'b100,
        ST_PROG   = 3'b101
    } ctl_state_e;
    typedef enum logic [1:0] {
        UL_NONE  = 2'b00,
        UL_FIRST = 2'b01,
        UL_READY = 2'b10
    } unlock_state_e;
endpackage

//--- hw/self_program_flash_controller.sv
// Operation
// - access in second cycle, suppress that instruction
// - data registers hold fetched word until changed
// - self-write only to unprotected segments
// - four-word aligned blocks, no boundary span
// - buffer offsets in order; offset 3 commits
// - commit programs four; erases sixteen only at low nibble 0011
// - two setup cycles after write bit
// - first three words just fill buffer
// - stall execution during erase, typical 4 ms
// - resume at third instruction after write
// - erase only when low nibble is 0011
// - power-up clears write permit
// - power-up timer blocks writes for 72 ms
// - protect bits only self-writes; code protect blocks serial
// - code protect keeps CPU access, blocks test area
// - protected regions readable, not modifiable
// - unlock port has no storage, reads zero
// - hardware clears write and read bits
// - data high six bits, address high four
// - calibration select picks test area reads
`timescale 1ns/1ps
`include "flash_ctl_map.svh"
module self_program_flash_controller
    import flash_ctl_pkg::*;
#(
    parameter int ERASE_CYCLES   = (`ERASE_TIME_US * `CLOCK_MHZ),
    parameter int POWERUP_CYCLES = (`POWERUP_TIME_US * `CLOCK_MHZ)
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  writeData,
    input  wire logic        addrLowWrite,
    input  wire logic        addrHighWrite,
    input  wire logic        wordLowWrite,
    input  wire logic        wordHighWrite,
    input  wire logic        controlWrite,
    input  wire logic        unlockWrite,
    input  wire logic [1:0]  selfWriteProtectBits,
    input  wire logic        codeProtect,
    input  wire logic        serialProgWriteReq,
    input  wire logic [13:0] arrayReadData,
    output logic [7:0]       flashAddrLow,
    output logic [7:0]       flashAddrHigh,
    output logic [7:0]       flashWordLow,
    output logic [7:0]       flashWordHigh,
    output logic [7:0]       flashControl,
    output logic [7:0]       flashUnlockPort,
    output logic             suppressInstr,
    output logic             cpuStall,
    output logic [11:0]      arrayAddr,
    output logic             arrayRead,
    output logic             arrayTestArea,
    output logic             arrayErase,
    output logic             arrayProgram,
    output logic [13:0]      arrayProgData,
    output logic             serialProgWriteOk,
    output logic             writeRefused
);
    // one width serves both the power-up and the erase countdown
    localparam int TMAX = (POWERUP_CYCLES > ERASE_CYCLES) ? POWERUP_CYCLES : ERASE_CYCLES;
    localparam int CW = $clog2(TMAX + 1);

    typedef struct packed {
        ctl_state_e    state;
        unlock_state_e unlock;
        logic [7:0]    addrLow;
        logic [3:0]    addrHigh;
        logic [7:0]    wordLow;
        logic [5:0]    wordHigh;
        logic          calibration_space_select;
        logic          permit;
        logic          wrBit;
        logic          rdBit;
        logic [3:0][13:0] buffer;
        logic [1:0]    progIdx;
        logic [CW-1:0] timer;
        logic [CW-1:0] powerTimer;
        logic          suppress;
        logic          stall;
        logic          aRead;
        logic          aTest;
        logic          aErase;
        logic          aProg;
        logic [11:0]   aAddr;
        logic [13:0]   aData;
        logic          serialOk;
        logic          refused;
    } ctl_s;

    ctl_s cur;
    ctl_s next_cur;
    logic [1:0] rstSync;
    logic rstSyncN;

    // protect code 11 = none, 10 = lower quarter, 01 = lower half, 00 = all
    function automatic logic isProtected(input logic [1:0] bits, input logic [11:0] addr);
        case (bits)
            2'h3: isProtected = 1'b0;
            2'h2: isProtected = (addr[11:10] == 2'h0);
            2'h1: isProtected = (addr[11] == 1'b0);
            default: isProtected = 1'b1;
        endcase
    endfunction

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstSyncN = rstSync[1];

    always_comb begin
        logic [11:0] addr;
        logic        wrReq;
        addr = {cur.addrHigh, cur.addrLow};
        wrReq = 1'b0;
        next_cur = cur;
        next_cur.aRead = 1'b0;
        next_cur.aErase = 1'b0;
        next_cur.aProg = 1'b0;
        next_cur.suppress = 1'b0;
        next_cur.refused = 1'b0;
        if (cur.powerTimer != '0) begin
            next_cur.powerTimer = cur.powerTimer - CW'(1);
        end
        next_cur.serialOk = serialProgWriteReq && !codeProtect;
        if (addrLowWrite) next_cur.addrLow = writeData;
        if (addrHighWrite) next_cur.addrHigh = writeData[3:0];
        if (wordLowWrite) next_cur.wordLow = writeData;
        if (wordHighWrite) next_cur.wordHigh = writeData[5:0];
        if (unlockWrite) begin
            if (writeData == `UNLOCK_FIRST) next_cur.unlock = UL_FIRST;
            else if (writeData == `UNLOCK_SECOND && cur.unlock == UL_FIRST) next_cur.unlock = UL_READY;
            else next_cur.unlock = UL_NONE;
        end
        if (controlWrite) begin
            next_cur.calibration_space_select = writeData[`CTRL_CALIBRATION_SPACE_SELECT_BIT];
            next_cur.permit = writeData[`CTRL_PERMIT_BIT];
            next_cur.unlock = UL_NONE;
            if (cur.state == ST_IDLE) begin
                if (writeData[`CTRL_READ_BIT]) begin
                    next_cur.rdBit = 1'b1;
                    next_cur.state = ST_RDWAIT;
                end else if (writeData[`CTRL_WRITE_BIT]) begin
                    wrReq = 1'b1;
                end
            end
        end
        if (wrReq) begin
            if (cur.unlock == UL_READY && cur.permit && cur.powerTimer == '0 &&
                !isProtected(selfWriteProtectBits, addr)) begin
                next_cur.wrBit = 1'b1;
                next_cur.buffer[cur.addrLow[1:0]] = {cur.wordHigh, cur.wordLow};
                next_cur.timer = CW'(`SETUP_CYCLES - 1);
                next_cur.state = ST_SETUP;
            end else begin
                next_cur.refused = 1'b1;
            end
        end
        case (cur.state)
            ST_IDLE: begin
            end
            ST_RDWAIT: begin
                next_cur.state = ST_RDACC;
                next_cur.aRead = 1'b1;
                next_cur.aAddr = addr;
                next_cur.aTest = cur.calibration_space_select && !codeProtect;
                next_cur.suppress = 1'b1;
            end
            ST_RDACC: begin
                next_cur.wordLow = arrayReadData[7:0];
                next_cur.wordHigh = arrayReadData[13:8];
                next_cur.rdBit = 1'b0;
                next_cur.state = ST_IDLE;
            end
            ST_SETUP: begin
                if (cur.timer != '0) begin
                    next_cur.timer = cur.timer - CW'(1);
                end else if (cur.addrLow[1:0] != `BLOCK_LAST) begin
                    next_cur.wrBit = 1'b0;
                    next_cur.state = ST_IDLE;
                end else begin
                    next_cur.stall = 1'b1;
                    next_cur.progIdx = 2'h0;
                    if (cur.addrLow[3:0] == `ROW_FIRST_LAST) begin
                        next_cur.aErase = 1'b1;
                        next_cur.aAddr = {addr[11:4], 4'h0};
                        next_cur.timer = CW'(ERASE_CYCLES - 1);
                        next_cur.state = ST_ERASE;
                    end else begin
                        next_cur.state = ST_PROG;
                    end
                end
            end
            ST_ERASE: begin
                if (cur.timer != '0) next_cur.timer = cur.timer - CW'(1);
                else next_cur.state = ST_PROG;
            end
            ST_PROG: begin
                next_cur.aProg = 1'b1;
                next_cur.aAddr = {addr[11:2], cur.progIdx};
                next_cur.aData = cur.buffer[cur.progIdx];
                next_cur.progIdx = cur.progIdx + 2'h1;
                if (cur.progIdx == `BLOCK_LAST) begin
                    next_cur.stall = 1'b0;
                    next_cur.wrBit = 1'b0;
                    next_cur.state = ST_IDLE;
                end
            end
            default: next_cur.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cur.state <= ST_IDLE;
            cur.unlock <= UL_NONE;
            cur.addrLow <= 8'h00;
            cur.addrHigh <= 4'h0;
            cur.wordLow <= 8'h00;
            cur.wordHigh <= 6'h00;
            cur.calibration_space_select <= 1'b0;
            cur.permit <= 1'b0;
            cur.wrBit <= 1'b0;
            cur.rdBit <= 1'b0;
            cur.buffer <= '0;
            cur.progIdx <= 2'h0;
            cur.timer <= '0;
            cur.powerTimer <= CW'(POWERUP_CYCLES);
            cur.suppress <= 1'b0;
            cur.stall <= 1'b0;
            cur.aRead <= 1'b0;
            cur.aTest <= 1'b0;
            cur.aErase <= 1'b0;
            cur.aProg <= 1'b0;
            cur.aAddr <= 12'h000;
            cur.aData <= 14'h0000;
            cur.serialOk <= 1'b0;
            cur.refused <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign flashAddrLow = cur.addrLow;
    assign flashAddrHigh = {4'h0, cur.addrHigh};
    assign flashWordLow = cur.wordLow;
    assign flashWordHigh = {2'h0, cur.wordHigh};
    assign flashControl = {1'b1, cur.calibration_space_select, 3'h0, cur.permit, cur.wrBit, cur.rdBit};
    assign flashUnlockPort = 8'h00;
    assign suppressInstr = cur.suppress;
    assign cpuStall = cur.stall;
    assign arrayAddr = cur.aAddr;
    assign arrayRead = cur.aRead;
    assign arrayTestArea = cur.aTest;
    assign arrayErase = cur.aErase;
    assign arrayProgram = cur.aProg;
    assign arrayProgData = cur.aData;
    assign serialProgWriteOk = cur.serialOk;
    assign writeRefused = cur.refused;

    read_single_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        (cur.state == ST_RDWAIT) |=> arrayRead ##1 !flashControl[`CTRL_READ_BIT]) else $error("read timing wrong");
    read_data_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        arrayRead |=> ({flashWordHigh[5:0], flashWordLow} == $past(arrayReadData)))
        else $error("read data not captured");
    permit_gate_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        (controlWrite && cur.state == ST_IDLE && writeData[`CTRL_WRITE_BIT] && !writeData[`CTRL_READ_BIT] &&
        !cur.permit) |=> !flashControl[`CTRL_WRITE_BIT]) else $error("write taken without permit");
    unlock_gate_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        (controlWrite && cur.state == ST_IDLE && cur.unlock != UL_READY) |=> !flashControl[`CTRL_WRITE_BIT])
        else $error("write taken without unlock");
    erase_only_row_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        arrayErase |-> arrayAddr[3:0] == 4'h0 && $past(cur.addrLow[3:0]) == `ROW_FIRST_LAST)
        else $error("erase at wrong address");
    no_stall_fill_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        (cur.state == ST_SETUP && cur.addrLow[1:0] != `BLOCK_LAST) |-> !cpuStall)
        else $error("stall on buffer fill");
    fill_done_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        ($rose(flashControl[`CTRL_WRITE_BIT]) && cur.addrLow[1:0] != `BLOCK_LAST) |-> ##[2:3]
        !flashControl[`CTRL_WRITE_BIT]) else $error("fill not finished in setup time");
    powerup_block_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        (cur.powerTimer != '0) |-> !arrayErase && !arrayProgram) else $error("write during power-up");
    serial_cp_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        $past(codeProtect) |-> !serialProgWriteOk) else $error("serial write under code protect");
    stall_on_erase_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        arrayErase |-> cpuStall) else $error("erase without stall");
    refused_idle_a: assert property (@(posedge clk) disable iff (!rstSyncN)
        writeRefused |-> !flashControl[`CTRL_WRITE_BIT]) else $error("refused write started");
endmodule

//--- testbench/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
    input  wire logic        clk,
    input  wire logic [11:0] arrayAddr,
    input  wire logic        arrayRead,
    input  wire logic        arrayTestArea,
    input  wire logic        arrayErase,
    input  wire logic        arrayProgram,
    input  wire logic [13:0] arrayProgData,
    output logic [13:0]      arrayReadData
);
    logic [13:0] mem [4096];
    logic [13:0] idleBus = 14'h2AAA;
    initial for (int i = 0; i < 4096; i++) mem[i] = 14'(i * 37 + 5);
    // data is only valid while read is strobed; otherwise the bus toggles
    assign arrayReadData = !arrayRead ? idleBus : (arrayTestArea ? 14'h1234 : mem[arrayAddr]);
    always @(posedge clk) begin
        idleBus <= ~idleBus;
        if (arrayErase) for (int i = 0; i < 16; i++) mem[{arrayAddr[11:4], 4'(i)}] <= 14'h3FFF;
        if (arrayProgram) mem[arrayAddr] <= arrayProgData;
    end
endmodule

//--- testbench/tb_self_program_flash_controller.sv
`timescale 1ns/1ps
module tb_self_program_flash_controller;
    import flash_ctl_pkg::*;
    localparam int ERASE = 20;
    logic        clk = 0;
    logic        arst_n = 0;
    logic [7:0]  writeData = 0;
    logic [5:0]  strobe = 0;
    logic [1:0]  protect = 2'h3;
    logic        codeProt = 0;
    logic        serReq = 0;
    logic [13:0] rdData, pData;
    logic [11:0] aAddr;
    logic [7:0]  aLo, aHi, wLo, wHi, ctl, unl;
    logic        supp, stall, rd, test, ers, prog, serOk, refused;
    int          mismatches = 0, check_count = 0, nErase = 0, nProg = 0, nRef = 0;
    self_program_flash_controller #(.ERASE_CYCLES(ERASE), .POWERUP_CYCLES(40)) uut (
        .clk(clk), .arst_n(arst_n), .writeData(writeData), .addrLowWrite(strobe[0]),
        .addrHighWrite(strobe[1]), .wordLowWrite(strobe[2]), .wordHighWrite(strobe[3]),
        .controlWrite(strobe[4]), .unlockWrite(strobe[5]), .selfWriteProtectBits(protect),
        .codeProtect(codeProt), .serialProgWriteReq(serReq), .arrayReadData(rdData),
        .flashAddrLow(aLo), .flashAddrHigh(aHi), .flashWordLow(wLo), .flashWordHigh(wHi),
        .flashControl(ctl), .flashUnlockPort(unl), .suppressInstr(supp), .cpuStall(stall),
        .arrayAddr(aAddr), .arrayRead(rd), .arrayTestArea(test), .arrayErase(ers),
        .arrayProgram(prog), .arrayProgData(pData), .serialProgWriteOk(serOk), .writeRefused(refused));
    flash_array_model far (.clk(clk), .arrayAddr(aAddr), .arrayRead(rd), .arrayTestArea(test),
        .arrayErase(ers), .arrayProgram(prog), .arrayProgData(pData), .arrayReadData(rdData));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        nErase += int'(ers);
        nProg += int'(prog);
        nRef += int'(refused);
    end
    function automatic logic [13:0] init_word(input logic [11:0] a);
        return 14'(a * 37 + 5);
    endfunction
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            $display("[ERR] %0t %s", $time, m);
            mismatches++;
        end
    endtask
    task automatic put(input int i, input logic [7:0] v);
        @(posedge clk);
        strobe <= 6'(1 << i);
        writeData <= v;
        @(posedge clk);
        strobe <= '0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rdw(input logic [11:0] a, input logic cal, input logic [13:0] e);
        put(0, a[7:0]);
        put(1, {4'hF, a[11:8]});
        #1 chk(aHi === {4'h0, a[11:8]}, "address high");
        put(4, {1'b1, cal, 6'h05});
        #1 chk(supp === 1'b0 && ctl[0] === 1'b1, "read slot one");
        cyc(1);
        chk(supp === 1'b1 && rd === 1'b1 && aAddr === a && test === (cal & ~codeProt), "read access");
        cyc(1);
        chk(ctl[0] === 1'b0 && supp === 1'b0, "read bit clear");
        chk({wHi, wLo} === {2'h0, e}, "read data");
    endtask
    // st counts stalled cycles, n counts cycles with the write bit up
    task automatic wr(input logic [11:0] a, input logic [13:0] d, input logic [7:0] k, output int st, output int n);
        put(0, a[7:0]);
        put(1, {4'hF, a[11:8]});
        put(2, d[7:0]);
        put(3, {2'h3, d[13:8]});
        #1 chk(wHi === {2'h0, d[13:8]}, "data high");
        xfer(k, st, n);
    endtask
    // unlock and write-bit set using whatever the address and data registers hold
    task automatic xfer(input logic [7:0] k, output int st, output int n);
        put(5, k);
        put(5, 8'hAA);
        #1 chk(unl === 8'h00, "unlock port");
        put(4, 8'h86);
        #1;
        n = 0;
        st = 0;
        while (ctl[1] === 1'b1 && n < 1000) begin
            n++;
            st += int'(stall);
            cyc(1);
        end
        chk(n < 1000, "write hang");
        if (n >= 1000) end_of_test();
    endtask
    initial begin
        int st, n, e0, p0, r0;
        logic [13:0] d [4];
        logic [11:0] a;
        void'($urandom(32'h0629));
        cyc(2);
        chk(ctl === 8'h80 && aLo === 8'h00 && wHi === 8'h00 && unl === 8'h00, "reset values");
        @(posedge clk) arst_n <= 1'b1;
        @(posedge clk);
        put(4, 8'h84);
        r0 = nRef;
        wr(12'h013, 14'h0, 8'h55, st, n);
        cyc(2);
        chk(n == 0 && nRef == r0 + 1, "power-up write");
        for (int i = 0; i < 8; i++) begin
            a = 12'($urandom);
            codeProt <= i[0];
            rdw(a, 1'b0, init_word(a));
        end
        codeProt <= 1'b0;
        rdw(12'h005, 1'b1, 14'h1234);
        codeProt <= 1'b1;
        serReq <= 1'b1;
        rdw(12'h005, 1'b1, init_word(12'h005));
        chk(serOk === 1'b0, "serial blocked");
        codeProt <= 1'b0;
        cyc(3);
        chk(serOk === 1'b1, "serial allowed");
        for (int p = 0; p < 4; p++) begin
            protect <= 2'(p);
            r0 = nRef;
            wr(12'h013, 14'h0, p == 3 ? 8'hAA : 8'h55, st, n);
            cyc(2);
            chk(n == 0 && nRef == r0 + 1, "refused write");
        end
        protect <= 2'h3;
        put(4, 8'h80);
        r0 = nRef;
        wr(12'h013, 14'h0, 8'h55, st, n);
        cyc(2);
        chk(n == 0 && nRef == r0 + 1, "write without permit");
        for (int i = 0; i < 4; i++) begin
            d[i] = 14'($urandom);
            e0 = nErase;
            p0 = nProg;
            wr(12'h010 + 12'(i), d[i], 8'h55, st, n);
            cyc(1);
            if (i < 3) chk(st == 0 && n == 2 && nProg == p0 && nErase == e0, "buffer fill");
            else chk(st >= ERASE && st <= ERASE + 30 && nErase == e0 + 1 && nProg == p0 + 4, "commit");
        end
        for (int i = 0; i < 4; i++) rdw(12'h010 + 12'(i), 1'b0, d[i]);
        rdw(12'h01C, 1'b0, 14'h3FFF);
        for (int i = 0; i < 3; i++) begin
            rdw(12'h010 + 12'(i), 1'b0, d[i]);
            xfer(8'h55, st, n);
            chk(n == 2 && st == 0, "reload fill");
        end
        d[3] = 14'($urandom);
        wr(12'h013, d[3], 8'h55, st, n);
        cyc(1);
        for (int i = 0; i < 4; i++) rdw(12'h010 + 12'(i), 1'b0, d[i]);
        e0 = nErase;
        for (int i = 4; i < 8; i++) wr(12'h020 + 12'(i), 14'($urandom), 8'h55, st, n);
        chk(nErase == e0, "erase off row start");
        rdw(12'h020, 1'b0, init_word(12'h020));
        @(posedge clk) arst_n <= 1'b0;
        cyc(2);
        chk(ctl === 8'h80 && stall === 1'b0 && rd === 1'b0, "reset clears permit");
        end_of_test();
    end
endmodule
